/* design/lic_top.sv */
// Legacy interrupt collection, NMI gating and inactivity SMI
module lic_top import lic_pkg::*; #(
   parameter int IDLE_TIMEOUT_CYC = LIC_IDLE_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire lic_io_req_type io,
   output logic [7:0] io_rdata,
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_index,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   input wire logic serial_irq_stream,
   input wire logic [1:0] hdd_irq,
   input wire logic [3:0] pci_interrupt_lines_n,
   input wire logic legacy_channel_check_n,
   input wire logic pci_system_error_n,
   input wire logic pci_parity_error_n,
   input wire logic cpu_internal_error_a,
   input wire logic cpu_internal_error_b,
   input wire logic refresh_request,
   input wire logic speaker_tone_out,
   input wire logic int_ack,
   input wire logic pm_enable,
   input wire logic pm_activity,
   output logic cpu_int_request_n,
   output logic nmi_n,
   output logic system_mgmt_int_n,
   output logic [7:0] int_vector,
   output logic int_vector_valid,
   output logic speaker_data,
   output logic speaker_gate
);
   function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
      port_hit = (addr == port);
   endfunction : port_hit

   // Pin synchronisers
   logic [7:0] low_s, high_s;
   logic [3:0] pci_act;
   logic chk_act, serr_act, perr_act, sirq_s;
   logic hdd14_s, hdd15_s, ierr_a_s, ierr_b_s, ref_s, spk_s, ack_s, pm_en_s, pm_act_s;

   lic_sync #(.WIDTH(8), .INIT(8'hFF)) u_sync_low (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({pci_interrupt_lines_n, legacy_channel_check_n, pci_system_error_n,
                 pci_parity_error_n, serial_irq_stream}),
      .sync_out(low_s)
   );

   lic_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_high (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({hdd_irq, cpu_internal_error_a, cpu_internal_error_b, refresh_request,
                 speaker_tone_out, int_ack, pm_activity}),
      .sync_out(high_s)
   );

   logic pm_en_meta_ff, pm_en_ff;

   always_comb begin
      pci_act = ~low_s[7:4];
      chk_act = !low_s[3];
      serr_act = !low_s[2];
      perr_act = !low_s[1];
      sirq_s = low_s[0];
      {hdd15_s, hdd14_s} = high_s[7:6];
      ierr_a_s = high_s[5];
      ierr_b_s = high_s[4];
      ref_s = high_s[3];
      spk_s = high_s[2];
      ack_s = high_s[1];
      pm_act_s = high_s[0];
      pm_en_s = pm_en_ff;
   end

   // Serial request stream: start frame low, then one sampled slot per line
   lic_sirq_state_type sirq_st_ff, nxt_sirq_st;
   logic [3:0] slot_ff, nxt_slot;
   logic [1:0] phase_ff, nxt_phase;
   logic [15:0] sirq_lvl_ff, nxt_sirq_lvl;

   always_comb begin
      nxt_sirq_st = sirq_st_ff;
      nxt_slot = slot_ff;
      nxt_phase = phase_ff;
      nxt_sirq_lvl = sirq_lvl_ff;
      case (sirq_st_ff)
         LIC_SIRQ_IDLE: begin
            if (!sirq_s) nxt_sirq_st = LIC_SIRQ_START;
         end
         LIC_SIRQ_START: begin
            if (sirq_s) begin
               nxt_sirq_st = LIC_SIRQ_SLOT;
               nxt_slot = 4'h0;
               nxt_phase = 2'h0;
            end
         end
         LIC_SIRQ_SLOT: begin
            if (phase_ff == 2'h0) nxt_sirq_lvl[slot_ff] = !sirq_s;
            if (phase_ff == 2'(LIC_SIRQ_SLOT_CYC - 1)) begin
               nxt_phase = 2'h0;
               nxt_slot = slot_ff + 4'h1;
               if (slot_ff == 4'(LIC_SIRQ_SLOTS - 1)) nxt_sirq_st = LIC_SIRQ_IDLE;
            end else begin
               nxt_phase = phase_ff + 2'h1;
            end
         end
         default: nxt_sirq_st = LIC_SIRQ_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sirq_st_ff <= LIC_SIRQ_IDLE;
         slot_ff <= 4'h0;
         phase_ff <= 2'h0;
         sirq_lvl_ff <= 16'h0000;
      end else begin
         sirq_st_ff <= nxt_sirq_st;
         slot_ff <= nxt_slot;
         phase_ff <= nxt_phase;
         sirq_lvl_ff <= nxt_sirq_lvl;
      end
   end

   // PCI steering bytes
   logic [7:0] route_ff [4];
   logic [7:0] nxt_route [4];

   always_comb begin
      for (int r = 0; r < 4; r++) begin
         nxt_route[r] = route_ff[r];
      end
      if (cfg_wr) nxt_route[cfg_index] = cfg_wdata;
      cfg_rdata = route_ff[cfg_index];
   end

   always_ff @(posedge clock) begin
      for (int r = 0; r < 4; r++) begin
         if (!rst_n) route_ff[r] <= LIC_ROUTE_RESET;
         else route_ff[r] <= nxt_route[r];
      end
   end

   // Request merge into the cascaded pair
   logic [15:0] irq_lines;
   logic [7:0] pri_req, sec_req;
   logic pri_int, sec_int;
   logic [2:0] pri_win, sec_win;
   logic [7:0] pri_vec, sec_vec, pri_rdata, sec_rdata;
   lic_pic_bus_type pri_bus, sec_bus;
   logic ack_d_ff, ack_pulse, pri_ack, sec_ack;

   always_comb begin
      irq_lines = sirq_lvl_ff;
      irq_lines[14] = irq_lines[14] | hdd14_s;
      irq_lines[15] = irq_lines[15] | hdd15_s;
      for (int r = 0; r < 4; r++) begin
         if (!route_ff[r][LIC_ROUTE_OFF_BIT] && pci_act[r]) irq_lines[route_ff[r][3:0]] = 1'b1;
      end
      sec_req = irq_lines[15:8];
      pri_req = irq_lines[7:0];
      // Lower index wins inside each controller, so 8..15 rank between 1 and 3
      pri_req[LIC_CASCADE_LINE] = sec_int;
      pri_bus.wr = io.wr && (port_hit(io.addr, LIC_PRI_CMD_PORT) || port_hit(io.addr, LIC_PRI_MASK_PORT));
      pri_bus.a0 = io.addr[0];
      pri_bus.wdata = io.wdata;
      sec_bus.wr = io.wr && (port_hit(io.addr, LIC_SEC_CMD_PORT) || port_hit(io.addr, LIC_SEC_MASK_PORT));
      sec_bus.a0 = io.addr[0];
      sec_bus.wdata = io.wdata;
      ack_pulse = ack_s && !ack_d_ff;
      pri_ack = ack_pulse;
      sec_ack = ack_pulse && pri_int && (pri_win == 3'(LIC_CASCADE_LINE));
   end

   lic_pic u_pic_pri (
      .clock(clock),
      .rst_n(rst_n),
      .bus(pri_bus),
      .req(pri_req),
      .ack(pri_ack),
      .int_out(pri_int),
      .win_id(pri_win),
      .vector(pri_vec),
      .rdata(pri_rdata)
   );

   lic_pic u_pic_sec (
      .clock(clock),
      .rst_n(rst_n),
      .bus(sec_bus),
      .req(sec_req),
      .ack(sec_ack),
      .int_out(sec_int),
      .win_id(sec_win),
      .vector(sec_vec),
      .rdata(sec_rdata)
   );

   // Status/control, NMI and SMI state
   logic [3:0] ctrl_ff, nxt_ctrl;
   logic par_ff, chk_ff, ref_tgl_ff, ref_d_ff, mask_ff;
   logic nxt_par, nxt_chk, nxt_ref_tgl, nxt_mask;
   logic nmi_req, nmi_n_ff, cpu_int_request_n_n_ff, smi_n_ff;
   logic [31:0] idle_ff, nxt_idle;
   logic [7:0] hold_ff, nxt_hold;
   logic [7:0] vec_ff, nxt_vec, rdata_ff, nxt_rdata;
   logic vec_vld_ff;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_mask = mask_ff;
      if (io.wr && port_hit(io.addr, LIC_SYS_CTRL_PORT)) nxt_ctrl = io.wdata[3:0];
      if (io.wr && port_hit(io.addr, LIC_NMI_MASK_PORT)) nxt_mask = io.wdata[LIC_NMI_MASK_BIT];
      // Disable bit holds status clear for as long as it stays set
      nxt_par = (par_ff || serr_act || perr_act || ierr_a_s || ierr_b_s) && !ctrl_ff[LIC_CTRL_PAR_DIS_BIT];
      nxt_chk = (chk_ff || chk_act) && !ctrl_ff[LIC_CTRL_CHK_DIS_BIT];
      nxt_ref_tgl = ref_tgl_ff ^ (ref_s && !ref_d_ff);
      nmi_req = !mask_ff && (par_ff || chk_ff);
      // Inactivity watch; the hold counter stretches SMI to a visible width
      nxt_hold = (hold_ff != 8'h00) ? hold_ff - 8'h01 : 8'h00;
      if (!pm_en_s || pm_act_s) begin
         nxt_idle = 32'h0000_0000;
      end else if (idle_ff == 32'(IDLE_TIMEOUT_CYC - 1)) begin
         nxt_idle = 32'h0000_0000;
         nxt_hold = 8'(LIC_SMI_HOLD_CYC);
      end else begin
         nxt_idle = idle_ff + 32'h0000_0001;
      end
      nxt_vec = sec_ack ? sec_vec : pri_vec;
      case (1'b1)
         port_hit(io.addr, LIC_PRI_CMD_PORT), port_hit(io.addr, LIC_PRI_MASK_PORT): nxt_rdata = pri_rdata;
         port_hit(io.addr, LIC_SEC_CMD_PORT), port_hit(io.addr, LIC_SEC_MASK_PORT): nxt_rdata = sec_rdata;
         port_hit(io.addr, LIC_SYS_CTRL_PORT): nxt_rdata = {par_ff, chk_ff, spk_s, ref_tgl_ff, ctrl_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pm_en_meta_ff <= 1'b0;
         pm_en_ff <= 1'b0;
         ctrl_ff <= LIC_CTRL_RESET;
         mask_ff <= LIC_NMI_MASK_RESET;
         par_ff <= 1'b0;
         chk_ff <= 1'b0;
         ref_tgl_ff <= 1'b0;
         ref_d_ff <= 1'b0;
         ack_d_ff <= 1'b0;
         idle_ff <= 32'h0000_0000;
         hold_ff <= 8'h00;
         nmi_n_ff <= 1'b1;
         cpu_int_request_n_n_ff <= 1'b1;
         smi_n_ff <= 1'b1;
         vec_ff <= LIC_VEC_RESET;
         vec_vld_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         pm_en_meta_ff <= pm_enable;
         pm_en_ff <= pm_en_meta_ff;
         ctrl_ff <= nxt_ctrl;
         mask_ff <= nxt_mask;
         par_ff <= nxt_par;
         chk_ff <= nxt_chk;
         ref_tgl_ff <= nxt_ref_tgl;
         ref_d_ff <= ref_s;
         ack_d_ff <= ack_s;
         idle_ff <= nxt_idle;
         hold_ff <= nxt_hold;
         // Lower-ranked requests are held off while a higher class is asserted
         smi_n_ff <= (nxt_hold == 8'h00);
         nmi_n_ff <= !(nmi_req && nxt_hold == 8'h00);
         cpu_int_request_n_n_ff <= !(pri_int && !nmi_req && nxt_hold == 8'h00);
         if (pri_ack && pri_int) vec_ff <= nxt_vec;
         vec_vld_ff <= pri_ack && pri_int;
         if (io.rd) rdata_ff <= nxt_rdata;
      end
   end

   assign io_rdata = rdata_ff;
   assign cpu_int_request_n = cpu_int_request_n_n_ff;
   assign nmi_n = nmi_n_ff;
   assign system_mgmt_int_n = smi_n_ff;
   assign int_vector = vec_ff;
   assign int_vector_valid = vec_vld_ff;
   assign speaker_data = ctrl_ff[LIC_CTRL_SPK_DATA_BIT];
   assign speaker_gate = ctrl_ff[LIC_CTRL_SPK_GATE_BIT];

   property p_route_reset;
      @(posedge clock) disable iff (!rst_n)
      !$past(rst_n) |-> route_ff[0][7] && route_ff[1][7] && route_ff[2][7] && route_ff[3][7];
   endproperty
   a_route_reset: assert property (p_route_reset) else $error("steering route enabled after reset");

   property p_nmi_out;
      @(posedge clock) disable iff (!rst_n)
      (!mask_ff && par_ff && nxt_hold == 8'h00) |=> !nmi_n;
   endproperty
   a_nmi_out: assert property (p_nmi_out) else $error("parity status did not drive NMI low");

   property p_par_clear;
      @(posedge clock) disable iff (!rst_n)
      ctrl_ff[LIC_CTRL_PAR_DIS_BIT] |=> !par_ff;
   endproperty
   a_par_clear: assert property (p_par_clear) else $error("parity status survived its disable bit");

   property p_chk_clear;
      @(posedge clock) disable iff (!rst_n)
      ctrl_ff[LIC_CTRL_CHK_DIS_BIT] |=> !chk_ff;
   endproperty
   a_chk_clear: assert property (p_chk_clear) else $error("channel-check status survived its disable bit");

   property p_nmi_mask;
      @(posedge clock) disable iff (!rst_n)
      (io.wr && io.addr == LIC_NMI_MASK_PORT && io.wdata == 8'h80) |=> ##1 nmi_n;
   endproperty
   a_nmi_mask: assert property (p_nmi_mask) else $error("NMI still low after mask write");

   property p_refresh;
      @(posedge clock) disable iff (!rst_n)
      (ref_s && !ref_d_ff) |=> (ref_tgl_ff != $past(ref_tgl_ff));
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh bit did not toggle");

   property p_smi;
      @(posedge clock) disable iff (!rst_n)
      (pm_en_s && !pm_act_s && idle_ff == 32'(IDLE_TIMEOUT_CYC - 1)) |=> !system_mgmt_int_n [*2];
   endproperty
   a_smi: assert property (p_smi) else $error("SMI not asserted on timeout");

   property p_cpu_int_request_n;
      @(posedge clock) disable iff (!rst_n)
      (pri_int && !nmi_req && nxt_hold == 8'h00) |=> !cpu_int_request_n;
   endproperty
   a_cpu_int_request_n: assert property (p_cpu_int_request_n) else $error("pending request did not reach the CPU");
endmodule : lic_top

/* design/lic_pkg.sv */
// Shared constants, carriers and state types for the legacy interrupt and NMI logic
package lic_pkg;
   localparam logic [15:0] LIC_PRI_CMD_PORT = 16'h0020;
   localparam logic [15:0] LIC_PRI_MASK_PORT = 16'h0021;
   localparam logic [15:0] LIC_SYS_CTRL_PORT = 16'h0061;
   localparam logic [15:0] LIC_NMI_MASK_PORT = 16'h0070;
   localparam logic [15:0] LIC_SEC_CMD_PORT = 16'h00A0;
   localparam logic [15:0] LIC_SEC_MASK_PORT = 16'h00A1;
   // Status/control port bit positions
   localparam int LIC_STAT_PAR_BIT = 7;
   localparam int LIC_STAT_CHK_BIT = 6;
   localparam int LIC_STAT_SPK_BIT = 5;
   localparam int LIC_STAT_REF_BIT = 4;
   localparam int LIC_CTRL_CHK_DIS_BIT = 3;
   localparam int LIC_CTRL_PAR_DIS_BIT = 2;
   localparam int LIC_CTRL_SPK_DATA_BIT = 1;
   localparam int LIC_CTRL_SPK_GATE_BIT = 0;
   localparam logic [3:0] LIC_CTRL_RESET = 4'h0;
   localparam int LIC_NMI_MASK_BIT = 7;
   localparam logic LIC_NMI_MASK_RESET = 1'b1;
   // Steering bytes: bit 7 set turns the route off, low nibble picks the line
   localparam int LIC_ROUTE_OFF_BIT = 7;
   localparam logic [7:0] LIC_ROUTE_RESET = 8'h80;
   localparam int LIC_CASCADE_LINE = 2;
   // Controller command decode
   localparam int LIC_ICW1_BIT = 4;
   localparam int LIC_OCW3_BIT = 3;
   localparam logic [2:0] LIC_EOI_NONSPEC = 3'h1;
   localparam logic [2:0] LIC_EOI_SPEC = 3'h3;
   localparam logic [7:0] LIC_VEC_RESET = 8'h00;
   // Timing
   localparam int LIC_CLK_NS = 40;
   localparam int LIC_SMI_HOLD_NS = 400;
   localparam int LIC_SMI_HOLD_CYC = (LIC_SMI_HOLD_NS + LIC_CLK_NS - 1) / LIC_CLK_NS;
   localparam int LIC_IDLE_TIMEOUT_CYC = 25_000_000;
   localparam int LIC_SIRQ_SLOT_CYC = 3;
   localparam int LIC_SIRQ_SLOTS = 16;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } lic_io_req_type;

   typedef struct packed {
      logic wr;
      logic a0;
      logic [7:0] wdata;
   } lic_pic_bus_type;

   typedef enum {LIC_SIRQ_IDLE, LIC_SIRQ_START, LIC_SIRQ_SLOT} lic_sirq_state_type;
   typedef enum {LIC_INIT_DONE, LIC_INIT_ICW2, LIC_INIT_ICW3, LIC_INIT_ICW4} lic_init_state_type;
endpackage : lic_pkg

/* design/lic_sync.sv */
// Two-flop synchroniser for pin inputs
module lic_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_ff <= INIT;
         sync_ff <= INIT;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule : lic_sync

/* design/lic_pic.sv */
// One eight-input edge-triggered interrupt controller with fully nested priority
module lic_pic import lic_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   input wire lic_pic_bus_type bus,
   input wire logic [7:0] req,
   input wire logic ack,
   output logic int_out,
   output logic [2:0] win_id,
   output logic [7:0] vector,
   output logic [7:0] rdata
);
   // Returns {none, index} of the lowest set bit; lowest index is highest priority
   function automatic logic [3:0] first_set(input logic [7:0] v);
      first_set = 4'h8;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) first_set = {1'b0, 3'(i)};
      end
   endfunction : first_set

   logic [7:0] irr_ff, imr_ff, isr_ff, req_d_ff, base_ff;
   logic [7:0] nxt_irr, nxt_imr, nxt_isr, nxt_base;
   logic single_ff, need4_ff, rd_isr_ff, nxt_single, nxt_need4, nxt_rd_isr;
   lic_init_state_type init_ff, nxt_init;
   logic [3:0] pend, serv;

   always_comb begin
      pend = first_set(irr_ff & ~imr_ff);
      serv = first_set(isr_ff);
      win_id = pend[2:0];
      int_out = !pend[3] && (serv[3] || (pend[2:0] < serv[2:0]));
      vector = {base_ff[7:3], pend[2:0]};
      rdata = bus.a0 ? imr_ff : (rd_isr_ff ? isr_ff : irr_ff);
      nxt_irr = irr_ff;
      nxt_imr = imr_ff;
      nxt_isr = isr_ff;
      nxt_base = base_ff;
      nxt_single = single_ff;
      nxt_need4 = need4_ff;
      nxt_rd_isr = rd_isr_ff;
      nxt_init = init_ff;
      if (ack && int_out) begin
         nxt_isr[pend[2:0]] = 1'b1;
         nxt_irr[pend[2:0]] = 1'b0;
      end
      if (bus.wr && !bus.a0) begin
         if (bus.wdata[LIC_ICW1_BIT]) begin
            nxt_imr = 8'h00;
            nxt_isr = 8'h00;
            nxt_single = bus.wdata[1];
            nxt_need4 = bus.wdata[0];
            nxt_rd_isr = 1'b0;
            nxt_init = LIC_INIT_ICW2;
         end else if (bus.wdata[LIC_OCW3_BIT]) begin
            if (bus.wdata[1]) nxt_rd_isr = bus.wdata[0];
         end else if (bus.wdata[7:5] == LIC_EOI_NONSPEC) begin
            if (!serv[3]) nxt_isr[serv[2:0]] = 1'b0;
         end else if (bus.wdata[7:5] == LIC_EOI_SPEC) begin
            nxt_isr[bus.wdata[2:0]] = 1'b0;
         end
      end else if (bus.wr) begin
         case (init_ff)
            LIC_INIT_ICW2: begin
               nxt_base = bus.wdata;
               nxt_init = !single_ff ? LIC_INIT_ICW3 : (need4_ff ? LIC_INIT_ICW4 : LIC_INIT_DONE);
            end
            LIC_INIT_ICW3: nxt_init = need4_ff ? LIC_INIT_ICW4 : LIC_INIT_DONE;
            LIC_INIT_ICW4: nxt_init = LIC_INIT_DONE;
            default: nxt_imr = bus.wdata;
         endcase
      end
      // A new edge wins over an acknowledge of the same line
      nxt_irr = nxt_irr | (req & ~req_d_ff);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irr_ff <= 8'h00;
         imr_ff <= 8'h00;
         isr_ff <= 8'h00;
         req_d_ff <= 8'h00;
         base_ff <= LIC_VEC_RESET;
         single_ff <= 1'b0;
         need4_ff <= 1'b0;
         rd_isr_ff <= 1'b0;
         init_ff <= LIC_INIT_DONE;
      end else begin
         irr_ff <= nxt_irr;
         imr_ff <= nxt_imr;
         isr_ff <= nxt_isr;
         req_d_ff <= req;
         base_ff <= nxt_base;
         single_ff <= nxt_single;
         need4_ff <= nxt_need4;
         rd_isr_ff <= nxt_rd_isr;
         init_ff <= nxt_init;
      end
   end

   property p_int_cause;
      @(posedge clock) disable iff (!rst_n)
      int_out |-> ((irr_ff & ~imr_ff) != 8'h00) && !imr_ff[win_id];
   endproperty
   a_int_cause: assert property (p_int_cause) else $error("request raised without unmasked pending line");

   property p_ack_service;
      @(posedge clock) disable iff (!rst_n)
      (ack && int_out && !bus.wr) |=> isr_ff[$past(win_id)];
   endproperty
   a_ack_service: assert property (p_ack_service) else $error("acknowledged line not put in service");
endmodule : lic_pic

/* test/lic_cpu_model.sv */
// Behavioural host core that acknowledges maskable requests
module lic_cpu_model #(
   parameter int ACK_DLY = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cpu_int_request_n,
   input wire logic [7:0] int_vector,
   input wire logic int_vector_valid,
   output logic int_ack,
   output logic [7:0] got_vec,
   output int n_got
);
   timeunit 1ns;
   timeprecision 1ps;
   int dly;
   // Ack is held until the vector shows, so a slow vector never loses a cycle
   always @(posedge clock) begin
      if (!rst_n) begin
         int_ack <= 1'b0;
         got_vec <= 8'h00;
         n_got <= 0;
         dly <= 0;
      end else if (int_ack) begin
         if (int_vector_valid === 1'b1) begin
            got_vec <= int_vector;
            n_got <= n_got + 1;
            int_ack <= 1'b0;
            dly <= 0;
         end
      end else if (cpu_int_request_n === 1'b0) begin
         if (dly == ACK_DLY) int_ack <= 1'b1;
         else dly <= dly + 1;
      end else dly <= 0;
   end
endmodule : lic_cpu_model

/* test/tb.sv */
// Self-checking bench for the legacy interrupt and NMI logic
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t %0h %0h", $time, g, e); end end
module tb import lic_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = '0, rst_n = '0, cfg_wr = '0, chk_n = '1, refr = '0, spk = '0, pm_en = '0, pm_act = '0;
   lic_io_req_type io = '0;
   logic [1:0] cfg_index = '0, hdd_irq = '0;
   logic [3:0] pci_interrupt_lines_n = 4'hF;
   logic [2:0] perr = '0;
   logic [7:0] cfg_wdata = '0, io_rdata, cfg_rdata, int_vector, got_vec, rd;
   logic int_req_n, nmi_n, smi_n, vvalid, spk_d, spk_g, int_ack;
   int errors = 0, n_checks = 0, n_got, cnt;
   logic [24:0] rows [11] = '{25'h100_6103, 25'h6103, 25'h100_6100, 25'h6100, 25'h7000, 25'h12_3400,
      25'h2100, 25'h100_21A5, 25'h21A5, 25'h100_A13C, 25'hA13C};
   logic [23:0] init [10] = '{24'h2011, 24'h2108, 24'h2104, 24'h2101, 24'hA011, 24'hA170, 24'hA102,
      24'hA101, 24'h2100, 24'hA100};
   always #20 clock = ~clock;
   lic_top #(.IDLE_TIMEOUT_CYC(20)) dut (.clock, .rst_n, .io, .io_rdata, .cfg_wr, .cfg_index, .cfg_wdata,
      .cfg_rdata, .serial_irq_stream(1'b1), .hdd_irq, .pci_interrupt_lines_n, .legacy_channel_check_n(chk_n),
      .pci_system_error_n(~perr[1]), .pci_parity_error_n(~perr[0]), .cpu_internal_error_a(perr[2]),
      .cpu_internal_error_b(1'b0), .refresh_request(refr), .speaker_tone_out(spk), .int_ack,
      .pm_enable(pm_en), .pm_activity(pm_act), .cpu_int_request_n(int_req_n), .nmi_n,
      .system_mgmt_int_n(smi_n), .int_vector, .int_vector_valid(vvalid), .speaker_data(spk_d),
      .speaker_gate(spk_g));
   lic_cpu_model #(.ACK_DLY(8)) cpu (.clock, .rst_n, .cpu_int_request_n(int_req_n), .int_vector,
      .int_vector_valid(vvalid), .int_ack, .got_vec, .n_got);
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock) io <= {1'b1, 1'b0, a, d};
      @(posedge clock) io <= '0;
   endtask : io_wr
   task automatic io_rd(input logic [15:0] a);
      @(posedge clock) io <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clock) io <= '0;
      @(posedge clock) #1 rd = io_rdata;
   endtask : io_rd
   task automatic cfg_put(input logic [1:0] i, input logic [7:0] d);
      @(posedge clock) {cfg_wr, cfg_index, cfg_wdata} <= {1'b1, i, d};
      @(posedge clock) cfg_wr <= 1'b0;
      @(posedge clock) #1;
   endtask : cfg_put
   task automatic wait_got(input int n, input logic [7:0] v);
      for (int i = 0; i < 300 && n_got < n; i++) @(posedge clock);
      `CHK(got_vec, v)
   endtask : wait_got
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   // Generous bound: the full run needs a few hundred cycles
   initial begin
      #800000;
      errors++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock) #1 `CHK({int_req_n, nmi_n, smi_n, vvalid}, 4'hE)
      for (int i = 0; i < 4; i++) begin
         @(posedge clock) cfg_index <= i[1:0];
         @(posedge clock) #1 `CHK(cfg_rdata, 8'h80)
      end
      foreach (rows[i]) begin
         if (rows[i][24]) begin
            io_wr(rows[i][23:8], rows[i][7:0]);
            @(posedge clock) #1;
            if (rows[i][23:8] == LIC_SYS_CTRL_PORT) `CHK({spk_d, spk_g}, rows[i][1:0])
         end else begin
            io_rd(rows[i][23:8]);
            `CHK(rd, rows[i][7:0])
         end
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge clock) {spk, refr} <= 2'h3;
         repeat (4) @(posedge clock);
         refr <= 1'b0;
         io_rd(LIC_SYS_CTRL_PORT);
         `CHK(rd, k ? 8'h20 : 8'h30)
      end
      @(posedge clock) perr <= 3'h1;
      repeat (6) @(posedge clock);
      io_rd(LIC_SYS_CTRL_PORT);
      `CHK({rd[7], nmi_n}, 2'h3)
      io_wr(LIC_NMI_MASK_PORT, 8'h00);
      repeat (3) @(posedge clock) #1 `CHK(nmi_n, 1'b0)
      io_wr(LIC_NMI_MASK_PORT, 8'h80);
      repeat (3) @(posedge clock) ;
      #1 `CHK(nmi_n, 1'b1)
      io_wr(LIC_NMI_MASK_PORT, 8'h00);
      for (int s = 0; s < 3; s++) begin
         @(posedge clock) perr <= 3'h1 << s;
         repeat (6) @(posedge clock);
         #1 `CHK(nmi_n, 1'b0)
         @(posedge clock) perr <= '0;
         io_wr(LIC_SYS_CTRL_PORT, 8'h04);
         repeat (3) @(posedge clock);
         #1 `CHK(nmi_n, 1'b1)
         io_wr(LIC_SYS_CTRL_PORT, 8'h00);
         io_rd(LIC_SYS_CTRL_PORT);
         `CHK(rd[7], 1'b0)
      end
      @(posedge clock) chk_n <= 1'b0;
      repeat (6) @(posedge clock);
      io_rd(LIC_SYS_CTRL_PORT);
      `CHK({rd[6], nmi_n}, 2'h2)
      io_wr(LIC_SYS_CTRL_PORT, 8'h08);
      @(posedge clock) chk_n <= 1'b1;
      io_rd(LIC_SYS_CTRL_PORT);
      `CHK({rd[6], nmi_n}, 2'h1)
      io_wr(LIC_SYS_CTRL_PORT, 8'h00);
      foreach (init[i]) io_wr(init[i][23:8], init[i][7:0]);
      cfg_put(2'h0, 8'h03);
      `CHK(cfg_rdata, 8'h03)
      // Line 14 and steered line 3 arrive together; the slave cascade must win
      @(posedge clock) {hdd_irq, pci_interrupt_lines_n} <= {2'h1, 4'hE};
      wait_got(1, 8'h76);
      repeat (3) @(posedge clock);
      #1 `CHK(int_req_n, 1'b1)
      io_wr(LIC_SEC_CMD_PORT, 8'h20);
      io_wr(LIC_PRI_CMD_PORT, 8'h20);
      wait_got(2, 8'h0B);
      io_wr(LIC_PRI_CMD_PORT, 8'h20);
      @(posedge clock) {hdd_irq, pci_interrupt_lines_n} <= {2'h0, 4'hF};
      cfg_put(2'h1, 8'h02);
      @(posedge clock) pci_interrupt_lines_n <= 4'hD;
      repeat (20) @(posedge clock);
      #1 `CHK(int_req_n, 1'b1)
      @(posedge clock) perr <= 3'h1;
      repeat (6) @(posedge clock);
      pm_en <= 1'b1;
      for (int i = 0; i < 100 && smi_n !== 1'b0; i++) @(posedge clock) #1;
      cnt = 0;
      while (smi_n === 1'b0 && cnt < 50) begin
         if (cnt == 3) `CHK(nmi_n, 1'b1)
         @(posedge clock) #1 cnt++;
      end
      `CHK(cnt, LIC_SMI_HOLD_CYC)
      @(posedge clock) pm_act <= 1'b1;
      cnt = 0;
      repeat (40) @(posedge clock) #1 cnt += int'(smi_n === 1'b0);
      `CHK(cnt, 0)
      final_report();
   end
endmodule : tb
